// ---- logic/fcb_branch_unit.sv ----
// Decoder and executor for branch-on-negative and branch-on-no-carry.
// Assumes one instruction word is presented per instruction cycle and that
// status flags are held by this unit; other non-zero words just advance the counter.
`timescale 1ns/1ps
module fcb_branch_unit #(
  parameter int unsigned PC_W = fcb_pkg::PC_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Instruction stream
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  // Status flags loaded by other instructions
  input wire logic [3:0] status_wr_data,
  input wire logic status_wr_en,
  // Observed state
  output logic [PC_W-1:0] program_counter,
  output logic [3:0] status_flags,
  output logic [1:0] phase,
  output logic fetch_ready,
  output logic branch_taken,
  output logic instr_done
);
  // Phase counter and cycle state.
  logic [1:0] phase_q;
  fcb_pkg::fcb_state_t state_q;

  // Instruction word and what decode keeps of it.
  logic [15:0] ir_q;
  logic [7:0] lit_q;
  logic is_branch_q;
  logic take_q;

  // Program counter and status flags.
  logic [PC_W-1:0] pc_q;
  logic [3:0] status_q;

  // One-clock completion pulses.
  logic taken_q;
  logic done_q;

  // Decodes shared by the processes below.
  logic phase_one;
  logic phase_two;
  logic phase_three;
  logic phase_four;
  logic exec_cycle;
  logic flush_cycle;
  logic hit_neg;
  logic hit_nc;
  logic neg_set;
  logic carry_clear;
  logic cond_met;
  logic seq_advance;
  logic jump_write;
  logic status_hold;
  logic [PC_W-1:0] offset_ext;

  // Exactly one phase strobe is high in every clock.
  always_comb begin
    phase_one = 1'b0;
    phase_two = 1'b0;
    phase_three = 1'b0;
    phase_four = 1'b0;
    case (phase_q)
      fcb_pkg::PH_ONE: begin
        phase_one = 1'b1;
      end
      fcb_pkg::PH_TWO: begin
        phase_two = 1'b1;
      end
      fcb_pkg::PH_THREE: begin
        phase_three = 1'b1;
      end
      fcb_pkg::PH_FOUR: begin
        phase_four = 1'b1;
      end
    endcase
  end

  assign exec_cycle = (state_q == fcb_pkg::FCB_EXEC);
  assign flush_cycle = (state_q == fcb_pkg::FCB_FLUSH);

  // Only the upper byte selects the branch; the lower byte is always the offset.
  always_comb begin
    hit_neg = 1'b0;
    hit_nc = 1'b0;
    if (ir_q[15:8] == fcb_pkg::OPC_BRANCH_NEG) begin
      hit_neg = 1'b1;
    end else if (ir_q[15:8] == fcb_pkg::OPC_BRANCH_NO_CARRY) begin
      hit_nc = 1'b1;
    end
  end

  assign neg_set = status_q[fcb_pkg::NEG_BIT];
  assign carry_clear = !status_q[fcb_pkg::CARRY_BIT];
  assign cond_met = (hit_neg && neg_set) || (hit_nc && carry_clear);

  // Sign extend then double, so the reach is -256 to +254 bytes.
  assign offset_ext = {{(PC_W-9){lit_q[7]}}, lit_q, 1'b0};

  // A zero word is a bubble and must not move the counter.
  assign seq_advance = exec_cycle && phase_one && (ir_q != 16'h0000);
  assign jump_write = exec_cycle && phase_four && take_q;

  // Flag loads are held off from decode of a branch to the end of its cycle, or of its flush if taken, so
  // the condition tested in phase three is the one in force at fetch.
  assign status_hold = flush_cycle || (exec_cycle && (hit_neg || hit_nc));

  // The phase counter free-runs; one lap is one instruction cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= fcb_pkg::PH_ONE;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // A taken branch spends the whole next cycle in flush, doing nothing.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= fcb_pkg::FCB_EXEC;
    end else begin
      case (state_q)
        fcb_pkg::FCB_EXEC: begin
          if (phase_four && take_q) begin
            state_q <= fcb_pkg::FCB_FLUSH;
          end
        end
        fcb_pkg::FCB_FLUSH: begin
          if (phase_four) begin
            state_q <= fcb_pkg::FCB_EXEC;
          end
        end
        default: begin
          state_q <= fcb_pkg::FCB_EXEC;
        end
      endcase
    end
  end

  // The word is latched at the phase-four edge; a missing word loads a bubble.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_q <= 16'h0000;
    end else if (exec_cycle && phase_four) begin
      if (instr_valid) begin
        ir_q <= instr_word;
      end else begin
        ir_q <= 16'h0000;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      is_branch_q <= 1'b0;
    end else if (exec_cycle && phase_one) begin
      is_branch_q <= hit_neg || hit_nc;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lit_q <= 8'h00;
    end else if (exec_cycle && phase_two) begin
      lit_q <= ir_q[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      take_q <= 1'b0;
    end else if (phase_three) begin
      take_q <= is_branch_q && exec_cycle && cond_met;
    end
  end

  // Sequential advance at phase one makes the jump base the counter plus two.
  // The counter wraps at its width, so a jump past either end lands modulo it.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= fcb_pkg::PC_RESET;
    end else if (seq_advance) begin
      pc_q <= pc_q + fcb_pkg::WORD_BYTES;
    end else if (jump_write) begin
      pc_q <= pc_q + offset_ext;
    end
  end

  // Branches never write the flags; only the external load path does.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= fcb_pkg::STATUS_RESET;
    end else if (status_wr_en && !status_hold) begin
      status_q <= status_wr_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= jump_write;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= phase_four && !(exec_cycle && take_q);
    end
  end

  assign program_counter = pc_q;
  assign status_flags = status_q;
  assign phase = phase_q;
  assign fetch_ready = phase_four && exec_cycle;
  assign branch_taken = taken_q;
  assign instr_done = done_q;
endmodule // fcb_branch_unit

// ---- logic/fcb_pkg.sv ----
// Constants for the flag conditional relative branch unit.
// Assumes a byte-addressed program counter with two-byte instruction words.
package fcb_pkg;
  localparam int unsigned PC_W = 21;
  localparam logic [7:0] OPC_BRANCH_NEG = 8'he6;
  localparam logic [7:0] OPC_BRANCH_NO_CARRY = 8'he3;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] WORD_BYTES = 21'h000002;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam int unsigned NEG_BIT = 3;
  localparam int unsigned CARRY_BIT = 0;
  localparam logic [1:0] PH_ONE = 2'h0;
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_THREE = 2'h2;
  localparam logic [1:0] PH_FOUR = 2'h3;
  typedef enum logic [1:0] {
    FCB_EXEC = 2'b01,
    FCB_FLUSH = 2'b10
  } fcb_state_t;
endpackage

// ---- sim/fcb_branch_unit_sva.sv ----
// Port assertions for the branch unit.
// Assumes the bench never loads flags on a fetch edge of a checked word.
`timescale 1ns/1ps
module fcb_chk #(parameter int unsigned PC_W = 21) (
  // Clock, reset and inputs
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic status_wr_en,
  // Outputs
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [3:0] status_flags,
  input wire logic [1:0] phase,
  input wire logic fetch_ready,
  input wire logic branch_taken,
  input wire logic instr_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic go = fetch_ready && instr_valid && !status_wr_en;
  wire logic br = instr_word[15:8] == 8'he6 || instr_word[15:8] == 8'he3;
  wire logic tk = (instr_word[15:8] == 8'he6 && status_flags[3]) ||
    (instr_word[15:8] == 8'he3 && !status_flags[0]);
  wire logic [PC_W-1:0] dx = {{(PC_W-9){instr_word[7]}}, instr_word[7:0], 1'b0};
  sequence s_fetch;
    go && instr_word != 16'h0000;
  endsequence
  property p_jump;
    logic [PC_W-1:0] t;
    (go && tk, t = program_counter + dx + PC_W'(2)) |=> ##4 program_counter == t
      ##3 (program_counter == t && phase == 2'h3 && !fetch_ready);
  endproperty
  property p_stay;
    logic [PC_W-1:0] t;
    (go && br && !tk, t = program_counter + PC_W'(2)) |=> ##3 program_counter == t
      ##1 !branch_taken;
  endproperty
  AST_PHASE: assert property (1 |=> phase == $past(phase) + 2'h1)
    else $error("phase did not step");
  AST_ADVANCE: assert property (s_fetch |=> ##1 program_counter - $past(program_counter) == PC_W'(2))
    else $error("counter did not advance one word");
  AST_JUMP: assert property (p_jump)
    else $error("jump target or flush wrong");
  AST_NO_JUMP: assert property (p_stay)
    else $error("untaken branch moved counter");
  AST_PULSE: assert property (branch_taken |-> phase == 2'h0 ##1 !branch_taken)
    else $error("taken pulse misplaced");
  AST_TAKEN_FLAG: assert property (go && tk |=> ##4 branch_taken)
    else $error("taken branch not flagged");
  AST_DECODE: assert property (go && !br && instr_word != 16'h0000 |=> ##4 !branch_taken)
    else $error("non-branch word jumped");
  AST_FLAGS: assert property (go && br |=> ##1 $stable(status_flags) [*3])
    else $error("flags changed in branch");
  AST_DONE: assert property (go && tk |=> ##4 !instr_done ##4 instr_done)
    else $error("taken branch did not end after its flush cycle");
endmodule // fcb_chk
bind fcb_branch_unit fcb_chk #(.PC_W(PC_W)) u_chk (.*);

// ---- sim/tb.sv ----
// Random bench with corner offsets for the branch unit.
// Assumes flags load one edge after the write enable and are ignored in a branch.
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic instr_valid = 1'b0;
  logic [3:0] status_wr_data = 4'h0;
  logic status_wr_en = 1'b0;
  logic [20:0] program_counter;
  logic [3:0] status_flags;
  logic [1:0] phase;
  logic fetch_ready;
  logic branch_taken;
  logic instr_done;
  int seed = 11;
  int err_count = 0;
  int num_checks = 0;
  always #2 ref_clk = ~ref_clk;
  fcb_branch_unit u_fcb_branch_unit (.*);
  function automatic logic tk(logic [15:0] w, logic [3:0] f);
    return (w[15:8] == 8'he6 && f[3]) || (w[15:8] == 8'he3 && !f[0]);
  endfunction
  task automatic chk_pc(string n, logic [20:0] e, logic [20:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_f(string n, logic [3:0] e, logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic op(logic [15:0] w, logic [3:0] f);
    logic [20:0] p;
    int i;
    i = 0;
    repeat (4) @(posedge ref_clk);
    status_wr_en <= 1'b1;
    status_wr_data <= f;
    @(posedge ref_clk);
    status_wr_en <= 1'b0;
    instr_word <= w;
    instr_valid <= 1'b1;
    do @(negedge ref_clk); while (fetch_ready !== 1'b1 && ++i < 20);
    if (i >= 20) begin
      err_count++;
      close_out();
    end
    p = program_counter;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    // Writes during the branch must be dropped, so offer inverted flags.
    status_wr_en <= 1'b1;
    status_wr_data <= ~f;
    repeat (3) @(posedge ref_clk);
    status_wr_en <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_pc("pc", p + 21'h2 + (tk(w, f) ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h0), program_counter);
    chk_f("flags", (w[15:8] == 8'he6 || w[15:8] == 8'he3) ? f : ~f, status_flags);
    chk_f("taken", {3'h0, tk(w, f)}, {3'h0, branch_taken});
    chk_f("done", {3'h0, !tk(w, f)}, {3'h0, instr_done});
  endtask
  initial begin
    logic [15:0] w;
    int k;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 64; k++) begin
      w = 16'($random(seed));
      w[15:8] = k % 3 == 0 ? 8'he6 : k % 3 == 1 ? 8'he3 : w[15:8] | 8'h01;
      if (k < 8) w[7:0] = k[1] ? 8'h80 : 8'h7f;
      op(w, 4'($random(seed)));
    end
    close_out();
  end
endmodule // tb
